/* File: hdl/dpm_lookup.sv */
// Lookup stage: maps a codepoint to its 2-bit priority, one cycle latency.
// Assumes the table on the carrier is the current register content.
`timescale 1ns/1ps
`default_nettype none
module dpm_lookup
  import dpm_pkg::*;
(
  input  wire logic     clk_sys,  // System clock
  input  wire logic     rstn,     // Async reset, active low
  dpm_lookup_if.lookup  lk        // Carrier from the bank
);

  logic                  resp_valid;
  logic [DPM_PRIO_W-1:0] resp_prio;
  logic                  resp_hit;
  logic                  next_valid;
  logic [DPM_PRIO_W-1:0] next_prio;
  logic                  next_hit;
  logic [5:0]            cp_rel;
  logic [4:0]            cp_off;

  // Table is sampled at the request edge, so a write in that cycle is not seen
  always_comb begin
    cp_rel     = lk.cp - DPM_CP_FIRST;
    cp_off     = cp_rel[4:0];
    next_valid = lk.req;
    next_hit   = lk.req && lk.ip_en && (lk.cp >= DPM_CP_FIRST) && (lk.cp <= DPM_CP_LAST);
    next_prio  = '0;
    if (next_hit) begin
      next_prio = lk.table_bits[{cp_off, 1'b0} +: DPM_PRIO_W];
    end
  end

  // Result registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resp_valid <= 1'b0;
      resp_prio  <= '0;
      resp_hit   <= 1'b0;
    end else begin
      resp_valid <= next_valid;
      resp_prio  <= next_prio;
      resp_hit   <= next_hit;
    end
  end

  assign lk.resp_valid = resp_valid;
  assign lk.resp_prio  = resp_prio;
  assign lk.resp_hit   = resp_hit;

endmodule
`default_nettype wire

/* File: hdl/dpm_slice.sv */
// Priority map slice for codepoints 0x18..0x37: eight byte registers and
// the classifier lookup. Assumes single-cycle management register strobes
// and a classifier that presents one TOS byte per request.
`timescale 1ns/1ps
`default_nettype none
module dpm_slice
  import dpm_pkg::*;
(
  input  wire logic                  clk_sys,      // System clock, 125 MHz
  input  wire logic                  rstn,         // Async reset, active low
  input  wire logic [7:0]            reg_addr,     // Register offset
  input  wire logic                  reg_wr_en,    // Write strobe, one cycle
  input  wire logic [7:0]            reg_wdata,    // Write data
  input  wire logic                  reg_rd_en,    // Read strobe, one cycle
  output logic      [7:0]            reg_rdata,    // Read data, registered
  output logic                       reg_rd_valid, // Read data valid pulse
  output logic                       reg_rd_hit,   // Read hit this slice
  input  wire logic                  lk_valid,     // Classifier lookup request
  input  wire logic [7:0]            lk_tos,       // TOS or Traffic Class byte
  input  wire logic                  lk_ip_en,     // IP based priority applies
  output logic                       lk_done,      // Lookup result pulse
  output logic                       lk_hit,       // Priority taken from slice
  output logic      [DPM_PRIO_W-1:0] lk_prio       // Resulting priority
);

  // Register storage, index 0 is offset 0x96
  logic [7:0] map_q      [DPM_NUM_REGS];
  logic [7:0] next_map   [DPM_NUM_REGS];
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  logic       rd_valid_q;
  logic       next_rd_valid;
  logic       rd_hit_q;
  logic       next_rd_hit;
  logic [2:0] addr_idx;
  logic       addr_hit;

  dpm_lookup_if lk_bus ();

  // Offset decode
  always_comb begin
    addr_idx = 3'h0;
    addr_hit = 1'b1;
    case (reg_addr)
      DPM_OFS_18_1B: addr_idx = 3'h0;
      DPM_OFS_1C_1F: addr_idx = 3'h1;
      DPM_OFS_20_23: addr_idx = 3'h2;
      DPM_OFS_24_27: addr_idx = 3'h3;
      DPM_OFS_28_2B: addr_idx = 3'h4;
      DPM_OFS_2C_2F: addr_idx = 3'h5;
      DPM_OFS_30_33: addr_idx = 3'h6;
      DPM_OFS_34_37: addr_idx = 3'h7;
      default:       addr_hit = 1'b0;
    endcase
  end

  // Next register state: write stores, read only samples
  always_comb begin
    for (int i = 0; i < DPM_NUM_REGS; i++) begin
      next_map[i] = map_q[i];
    end
    if (reg_wr_en && addr_hit) begin
      next_map[addr_idx] = reg_wdata;
    end
    next_rd_valid = reg_rd_en;
    next_rd_hit   = reg_rd_en && addr_hit;
    next_rdata    = rdata_q;
    if (reg_rd_en) begin
      next_rdata = addr_hit ? map_q[addr_idx] : DPM_RD_NONE;
    end
  end

  // Register bank flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
        map_q[i] <= DPM_REG_RST;
      end
      rdata_q    <= DPM_RD_NONE;
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end else begin
      for (int i = 0; i < DPM_NUM_REGS; i++) begin
        map_q[i] <= next_map[i];
      end
      rdata_q    <= next_rdata;
      rd_valid_q <= next_rd_valid;
      rd_hit_q   <= next_rd_hit;
    end
  end

  assign reg_rdata    = rdata_q;
  assign reg_rd_valid = rd_valid_q;
  assign reg_rd_hit   = rd_hit_q;

  // Flatten table for the lookup stage, codepoint order ascending
  always_comb begin
    for (int i = 0; i < DPM_NUM_REGS; i++) begin
      lk_bus.table_bits[i*8 +: 8] = map_q[i];
    end
  end

  // Lookup request, codepoint is the upper six TOS bits
  assign lk_bus.req   = lk_valid;
  assign lk_bus.cp    = lk_tos[7:DPM_CP_LSB];
  assign lk_bus.ip_en = lk_ip_en;

  dpm_lookup u_lookup (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .lk      (lk_bus.lookup)
  );

  assign lk_done = lk_bus.resp_valid;
  assign lk_hit  = lk_bus.resp_hit;
  assign lk_prio = lk_bus.resp_prio;

  // Checking helpers: expected field for the request codepoint, taken from
  // the register array itself so a broken flattening shows up
  logic [5:0]            chk_rel;
  logic [4:0]            chk_off;
  logic                  chk_in;
  logic [DPM_PRIO_W-1:0] chk_old;
  logic [DPM_PRIO_W-1:0] chk_new;
  assign chk_rel = lk_tos[7:DPM_CP_LSB] - DPM_CP_FIRST;
  assign chk_off = chk_rel[4:0];
  assign chk_old = map_q[chk_off[4:2]][{chk_off[1:0], 1'b0} +: DPM_PRIO_W];
  assign chk_new = reg_wdata[{chk_off[1:0], 1'b0} +: DPM_PRIO_W];
  assign chk_in  = (lk_tos[7:DPM_CP_LSB] >= DPM_CP_FIRST) &&
                   (lk_tos[7:DPM_CP_LSB] <= DPM_CP_LAST);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Each offset write lands in its own register on the next edge
  a_wr_reg_96: assert property (
    reg_wr_en && reg_addr == DPM_OFS_18_1B |=> map_q[0] == $past(reg_wdata))
    else $error("offset 0x96 write not stored");
  a_wr_reg_97: assert property (
    reg_wr_en && reg_addr == DPM_OFS_1C_1F |=> map_q[1] == $past(reg_wdata))
    else $error("offset 0x97 write not stored");
  a_wr_reg_98: assert property (
    reg_wr_en && reg_addr == DPM_OFS_20_23 |=> map_q[2] == $past(reg_wdata))
    else $error("offset 0x98 write not stored");
  a_wr_reg_99: assert property (
    reg_wr_en && reg_addr == DPM_OFS_24_27 |=> map_q[3] == $past(reg_wdata))
    else $error("offset 0x99 write not stored");
  a_wr_reg_9a: assert property (
    reg_wr_en && reg_addr == DPM_OFS_28_2B |=> map_q[4] == $past(reg_wdata))
    else $error("offset 0x9A write not stored");
  a_wr_reg_9b: assert property (
    reg_wr_en && reg_addr == DPM_OFS_2C_2F |=> map_q[5] == $past(reg_wdata))
    else $error("offset 0x9B write not stored");
  a_wr_reg_9c: assert property (
    reg_wr_en && reg_addr == DPM_OFS_30_33 |=> map_q[6] == $past(reg_wdata))
    else $error("offset 0x9C write not stored");
  a_wr_reg_9d: assert property (
    reg_wr_en && reg_addr == DPM_OFS_34_37 |=> map_q[7] == $past(reg_wdata))
    else $error("offset 0x9D write not stored");

  // Lookup result equals the field indexed by the codepoint
  a_lookup_field: assert property (
    lk_valid && lk_ip_en && chk_in |=> lk_done && lk_hit &&
      lk_prio == $past(chk_old))
    else $error("lookup priority does not match table field");

  // A write in the request cycle does not reach that lookup
  a_lookup_old: assert property (
    lk_valid && lk_ip_en && chk_in && reg_wr_en && addr_hit
      && addr_idx == chk_off[4:2] |=> lk_prio == $past(chk_old))
    else $error("lookup saw write from its own request cycle");

  // A lookup of the same codepoint one cycle after the write sees the new field
  a_lookup_new: assert property (
    lk_valid && lk_ip_en && chk_in && reg_wr_en && addr_hit && addr_idx == chk_off[4:2]
      ##1 lk_valid && lk_ip_en && lk_tos[7:DPM_CP_LSB] == $past(lk_tos[7:DPM_CP_LSB])
      |=> lk_prio == $past(chk_new, 2))
    else $error("lookup after write missed the new field");

  // Read returns stored value and leaves the table untouched
  a_read_back: assert property (
    reg_rd_en && addr_hit && !reg_wr_en |=> reg_rd_valid && reg_rd_hit &&
      reg_rdata == $past(map_q[addr_idx]) && lk_bus.table_bits == $past(lk_bus.table_bits))
    else $error("read data wrong or read disturbed table");

  // Miss or disabled lookup never reports a hit
  a_lookup_miss: assert property (
    lk_valid && !(lk_ip_en && chk_in) |=> lk_done && !lk_hit && lk_prio == 2'h0)
    else $error("lookup hit outside slice or with IP priority off");

endmodule
`default_nettype wire

/* File: pkg/dpm_lookup_if.sv */
// Carrier between the register bank and the lookup stage of the slice.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dpm_lookup_if;
  import dpm_pkg::*;
  logic [DPM_TBL_W-1:0]  table_bits;  // Flattened map, codepoint 0x18 at bits 1..0
  logic                  req;         // Lookup request
  logic [5:0]            cp;          // Codepoint of the request
  logic                  ip_en;       // IP based priority applies
  logic                  resp_valid;  // Result pulse
  logic [DPM_PRIO_W-1:0] resp_prio;   // Resulting priority
  logic                  resp_hit;    // Codepoint matched this slice

  modport bank   (output table_bits, req, cp, ip_en,
                  input  resp_valid, resp_prio, resp_hit);
  modport lookup (input  table_bits, req, cp, ip_en,
                  output resp_valid, resp_prio, resp_hit);
endinterface
`default_nettype wire

/* File: pkg/dpm_pkg.sv */
// Constants for the DiffServ priority map slice (codepoints 0x18..0x37).
// Assumes byte-wide management registers addressed by an 8-bit offset.
package dpm_pkg;

  // Register offsets, one byte register per four codepoints
  localparam logic [7:0] DPM_OFS_18_1B = 8'h96;
  localparam logic [7:0] DPM_OFS_1C_1F = 8'h97;
  localparam logic [7:0] DPM_OFS_20_23 = 8'h98;
  localparam logic [7:0] DPM_OFS_24_27 = 8'h99;
  localparam logic [7:0] DPM_OFS_28_2B = 8'h9A;
  localparam logic [7:0] DPM_OFS_2C_2F = 8'h9B;
  localparam logic [7:0] DPM_OFS_30_33 = 8'h9C;
  localparam logic [7:0] DPM_OFS_34_37 = 8'h9D;

  // Table geometry
  localparam int         DPM_NUM_REGS  = 8;
  localparam int         DPM_PRIO_W    = 2;
  localparam int         DPM_TBL_W     = DPM_NUM_REGS * 8;
  localparam logic [7:0] DPM_REG_RST   = 8'h00;
  localparam logic [7:0] DPM_RD_NONE   = 8'h00;

  // Codepoint window of this slice; codepoint is TOS bits 7..2
  localparam logic [5:0] DPM_CP_FIRST  = 6'h18;
  localparam logic [5:0] DPM_CP_LAST   = 6'h37;
  localparam int         DPM_CP_LSB    = 2;

endpackage

/* File: test/dpm_slice_tb.sv */
// Self-checking bench for the priority map slice: register access and lookups.
// Assumes the slice answers reads and lookups exactly one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpm_pkg::*;
  logic       clk_sys   = 1'b0;
  logic       rstn      = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic       reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_rd_en = 1'b0;
  logic       lk_valid  = 1'b0;
  logic [7:0] lk_tos    = 8'h00;
  logic       lk_ip_en  = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rd_valid;
  logic       reg_rd_hit;
  logic       lk_done;
  logic       lk_hit;
  logic [DPM_PRIO_W-1:0] lk_prio;
  int         n_fail    = 0;
  int         n_tests   = 0;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  dpm_slice uut (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .reg_addr     (reg_addr),
    .reg_wr_en    (reg_wr_en),
    .reg_wdata    (reg_wdata),
    .reg_rd_en    (reg_rd_en),
    .reg_rdata    (reg_rdata),
    .reg_rd_valid (reg_rd_valid),
    .reg_rd_hit   (reg_rd_hit),
    .lk_valid     (lk_valid),
    .lk_tos       (lk_tos),
    .lk_ip_en     (lk_ip_en),
    .lk_done      (lk_done),
    .lk_hit       (lk_hit),
    .lk_prio      (lk_prio)
  );

  // Distinct field pattern per register so a swapped field shows up
  function automatic logic [7:0] pat(input int i);
    return 8'h1B + 8'(i * 37);
  endfunction

  // Compare one value and count it
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask

  // Single-cycle read strobe, answer checked one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    chk("reg_rd_valid", {7'h00, reg_rd_valid}, 8'h01);
    chk("reg_rd_hit", {7'h00, reg_rd_hit}, {7'h00, hit});
    chk("reg_rdata", reg_rdata, exp);
  endtask

  // Single lookup, result checked one cycle later
  task automatic lk(input logic [7:0] tos, input logic ip, input logic hit, input logic [1:0] pr);
    @(posedge clk_sys);
    lk_valid <= 1'b1;
    lk_tos   <= tos;
    lk_ip_en <= ip;
    @(posedge clk_sys);
    lk_valid <= 1'b0;
    #1;
    chk("lk_done", {7'h00, lk_done}, 8'h01);
    chk("lk_hit", {7'h00, lk_hit}, {7'h00, hit});
    chk("lk_prio", {6'h00, lk_prio}, {6'h00, pr});
  endtask

  // Counts, verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0] v;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    // Reset values, plus unmapped reads on both sides of the slice
    for (int i = 0; i < DPM_NUM_REGS; i++) begin
      rd(DPM_OFS_18_1B + 8'(i), DPM_REG_RST, 1'b1);
    end
    rd(8'h95, DPM_RD_NONE, 1'b0);
    rd(8'h9E, DPM_RD_NONE, 1'b0);
    $display("Test reset values done");
    // Write every register, poke unmapped neighbours, read back
    for (int i = 0; i < DPM_NUM_REGS; i++) begin
      wr(DPM_OFS_18_1B + 8'(i), pat(i));
    end
    wr(8'h95, 8'hFF);
    wr(8'h9E, 8'hFF);
    for (int i = 0; i < DPM_NUM_REGS; i++) begin
      rd(DPM_OFS_18_1B + 8'(i), pat(i), 1'b1);
    end
    $display("Test register write and read done");
    // Every codepoint of the slice, low TOS bits set to show they are ignored
    for (int k = 0; k < 32; k++) begin
      v = pat(k / 4) >> (2 * (k % 4));
      lk({DPM_CP_FIRST + 6'(k), 2'b11}, 1'b1, 1'b1, v[1:0]);
    end
    lk({6'h17, 2'b00}, 1'b1, 1'b0, 2'b00);
    lk({6'h38, 2'b00}, 1'b1, 1'b0, 2'b00);
    lk({6'h1B, 2'b00}, 1'b0, 1'b0, 2'b00);
    $display("Test lookup done");
    // Write racing a lookup: first lookup sees old field, next one the new
    @(posedge clk_sys);
    reg_addr  <= DPM_OFS_18_1B;
    reg_wdata <= ~pat(0);
    reg_wr_en <= 1'b1;
    lk_valid  <= 1'b1;
    lk_tos    <= {DPM_CP_FIRST, 2'b00};
    lk_ip_en  <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    #1;
    v = pat(0);
    chk("lk_done", {7'h00, lk_done}, 8'h01);
    chk("lk_prio", {6'h00, lk_prio}, {6'h00, v[1:0]});
    @(posedge clk_sys);
    lk_valid <= 1'b0;
    #1;
    v = ~pat(0);
    chk("lk_done", {7'h00, lk_done}, 8'h01);
    chk("lk_prio", {6'h00, lk_prio}, {6'h00, v[1:0]});
    rd(DPM_OFS_18_1B, ~pat(0), 1'b1);
    // Read and write in one cycle: the read returns the value before the write
    @(posedge clk_sys);
    reg_addr  <= DPM_OFS_1C_1F;
    reg_wdata <= 8'h5A;
    reg_wr_en <= 1'b1;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, pat(1));
    rd(DPM_OFS_1C_1F, 8'h5A, 1'b1);
    $display("Test write during lookup done");
    test_done();
  end
endmodule
`default_nettype wire
